// [rtl/lics_pkg.sv]
// Functional notes
// RULE_01: Receive and transmit line modes are separate fields, chosen independently.
// RULE_02: In 6312kHz transmit mode the clock appears only on the payload clock.
// RULE_03: Jitter attenuator is enabled only when its side runs T1 or E1.
// RULE_04: Software picks receive termination by three bits; zero means external resistors.
// RULE_05: One gain-limit bit selects full or limited receive sensitivity.
// RULE_06: Receive clock output falls back to scaled master clock during signal loss.
// RULE_07: Jitter attenuator in receive path is flagged for a near 50% clock.
// RULE_08: Received level appears as a four-bit code in the information register.
// RULE_09: A receive mode accepts a square-wave sync clock on the receive input.
// RULE_10: A two-bit monitor field selects flat-gain settings of the receiver.
// RULE_11: Transmit waveform follows the four-bit mode field and build-out select.
// RULE_12: Transmit clock source is recovered, prescaled master, external, or PLL.
// RULE_13: Transmit pulse width is fixed, independent of the transmit clock duty.
// RULE_14: Fixed gain or automatic gain transmit drive is selectable.
// RULE_15: Current limiter stays on unless the limit-disable bit is set.
// RULE_16: Real-time current-limit flag plus latched copy that can raise interrupt.
// RULE_17: Real-time open-circuit flag plus latched copy that can raise interrupt.
// RULE_18: Power-down bit low disables driver and floats both transmit outputs.
// RULE_19: Rising insert bit arms one violation after three consecutive transmitted ones.
// RULE_20: Only one violation per rising edge; software clears and sets again.
// RULE_21: In E1 sync mode a square-wave clock goes out on the line.
// RULE_22: Latched bits set on rising condition, cleared by software; masked interrupt.
// RULE_23: Violation mark repeats the polarity of the previous mark.
package lics_pkg;
  localparam logic [7:0] ADR_LINE_CTRL_1 = 8'h30;
  localparam logic [7:0] ADR_TX_GAIN     = 8'h34;
  localparam logic [7:0] ADR_LINE_CTRL_2 = 8'h38;
  localparam logic [7:0] ADR_LINE_CTRL_3 = 8'h3C;
  localparam logic [7:0] ADR_LINE_CTRL_4 = 8'h40;
  localparam logic [7:0] ADR_MODE_CFG    = 8'h44;
  localparam logic [7:0] ADR_STATUS_ONE  = 8'h48;
  localparam logic [7:0] ADR_IRQ_MASK    = 8'h4C;
  localparam logic [7:0] ADR_INFO_ONE    = 8'h50;
  localparam logic [7:0] ADR_RT_STATUS   = 8'h54;

  localparam int LC1_PWR_N   = 0;
  localparam int LC1_JA_DIS  = 1;
  localparam int LC1_JA_32   = 2;
  localparam int LC1_JA_TX   = 3;
  localparam int LC1_GLIM    = 4;
  localparam int LC1_LBO_LO  = 5;
  localparam int TXG_AGC     = 6;
  localparam int LC2_SHORT_LIMIT_DISABLE    = 1;
  localparam int LC2_SRC_LO  = 2;
  localparam int LC2_BPV     = 5;
  localparam int SR_OPEN     = 1;
  localparam int SR_SHORT    = 2;
  localparam int INFO_LOS    = 4;
  localparam int MCR_RX_LO   = 4;

  localparam logic [3:0] MODE_T1   = 4'h0;
  localparam logic [3:0] MODE_E1   = 4'h1;
  localparam logic [3:0] MODE_CC   = 4'h2;
  localparam logic [3:0] MODE_6312 = 4'h3;
  localparam logic [3:0] MODE_SYNC = 4'h4;

  localparam logic [1:0] SRC_RECOV = 2'h0;
  localparam logic [1:0] SRC_MCLK  = 2'h1;
  localparam logic [1:0] SRC_TX_CLOCK_IN  = 2'h2;
  localparam logic [1:0] SRC_PLL   = 2'h3;

  localparam int CLK_NS       = 10;
  localparam int MCLK_HALF_NS = 244;
  localparam int TX_PULSE_NS  = 244;
  localparam logic [7:0] MCLK_HALF_CYC = 8'(MCLK_HALF_NS / CLK_NS);
  localparam logic [7:0] TX_PULSE_CYC  = 8'(TX_PULSE_NS / CLK_NS);
  localparam logic [1:0] BPV_RUN       = 2'h3;

  typedef enum logic [1:0] {
    BPV_IDLE  = 2'b01,
    BPV_ARMED = 2'b10
  } lics_bpv_e;

  typedef struct packed {
    logic [3:0] level;
    logic       los;
    logic       open_det;
    logic       short_det;
    logic       pll_clk;
    logic       tx_clock_in;
    logic       rclk;
    logic       rneg;
    logic       rpos;
  } lics_pins_s;

  typedef struct packed {
    logic [2:0] rx_term_sel;
    logic       rx_gain_limit;
    logic [1:0] monitor_gain_sel;
    logic [3:0] tx_waveform_mode;
    logic [2:0] line_buildout_sel;
    logic       agc_en;
    logic [5:0] gain_code;
    logic       current_limit_en;
    logic       ja_en;
    logic       ja_tx_side;
    logic       ja_depth_32;
    logic       ja_rx_path;
  } lics_cfg_s;

  typedef struct packed {
    lics_pins_s s1;
    lics_pins_s s2;
    logic [7:0] lc1;
    logic [7:0] txg;
    logic [7:0] lc2;
    logic [7:0] lc3;
    logic [7:0] lc4;
    logic [7:0] mcr;
    logic [2:1] sr;
    logic [2:1] imr;
    logic [2:1] rt_prev;
    logic       ack;
    logic [7:0] rdat;
    logic       irq;
    logic [7:0] div_cnt;
    logic       mclk_sc;
    logic       txclk_prev;
    logic [7:0] pulse_cnt;
    logic       last_pol;
    logic [1:0] ones;
    lics_bpv_e  bpv;
    logic       bpv_prev;
    logic       tx_pos;
    logic       tx_neg;
    logic       tx_oe_n;
    logic       take;
    logic       rx_clk;
    logic       pay_clk;
    lics_cfg_s  cfg;
  } lics_state_s;
endpackage

// [rtl/lics_line_ctrl.sv]
module lics_line_ctrl
  import lics_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rx_line_pos_i,
  input  wire logic        rx_line_neg_i,
  input  wire logic        rx_clk_rec_i,
  input  wire logic        tx_clock_in_i,
  input  wire logic        tx_pll_clk_i,
  input  wire logic        short_det_i,
  input  wire logic        open_det_i,
  input  wire logic        rx_signal_lost_i,
  input  wire logic [3:0]  rx_level_code_i,
  input  wire logic        tx_data_i,
  output logic             tx_line_pos_o,
  output logic             tx_line_neg_o,
  output logic             tx_line_oe_n_o,
  output logic             tx_bit_taken_o,
  output logic             rx_clock_out_o,
  output logic             tx_payload_clock_out_o,
  output logic             irq_o,
  output lics_cfg_s        cfg_o
);

  lics_state_s st_r;
  lics_state_s st_nxt;
  lics_pins_s  pins;
  logic        req;
  logic        tx_sel;
  logic        tx_rise;
  logic        bpv_fire;
  logic        pol;
  logic [2:1]  rt;
  logic [2:1]  clr;
  logic [3:0]  txm;
  logic [3:0]  rxm;
  logic [3:0]  ja_mode;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  assign pins = '{level:     rx_level_code_i,
                  los:       rx_signal_lost_i,
                  open_det:  open_det_i,
                  short_det: short_det_i,
                  pll_clk:   tx_pll_clk_i,
                  tx_clock_in:      tx_clock_in_i,
                  rclk:      rx_clk_rec_i,
                  rneg:      rx_line_neg_i,
                  rpos:      rx_line_pos_i};

  always_comb begin
    st_nxt   = st_r;
    req      = wb_cyc_i & wb_stb_i;
    txm      = st_r.mcr[MCR_RX_LO-1:0];                          // RULE_01
    rxm      = st_r.mcr[MCR_RX_LO+3:MCR_RX_LO];                  // RULE_01
    ja_mode  = st_r.lc1[LC1_JA_TX] ? txm : rxm;
    rt       = {st_r.s2.short_det, st_r.s2.open_det};  // RULE_16 RULE_17
    clr      = '0;
    tx_sel   = 1'b0;
    tx_rise  = 1'b0;
    bpv_fire = 1'b0;
    pol      = 1'b0;
    if (ce_i) begin
      st_nxt.s1 = pins;
      st_nxt.s2 = st_r.s1;

      // Bus: ack follows a fresh request by one cycle, then drops
      st_nxt.ack = req & ~st_r.ack;
      if (req & ~st_r.ack) begin
        case (wb_adr_i)
          ADR_LINE_CTRL_1: st_nxt.rdat = st_r.lc1;
          ADR_TX_GAIN:     st_nxt.rdat = st_r.txg;
          ADR_LINE_CTRL_2: st_nxt.rdat = st_r.lc2;
          ADR_LINE_CTRL_3: st_nxt.rdat = st_r.lc3;
          ADR_LINE_CTRL_4: st_nxt.rdat = st_r.lc4;
          ADR_MODE_CFG:    st_nxt.rdat = st_r.mcr;
          ADR_STATUS_ONE:  st_nxt.rdat = {5'h00, st_r.sr, 1'b0};
          ADR_IRQ_MASK:    st_nxt.rdat = {5'h00, st_r.imr, 1'b0};
          ADR_INFO_ONE:
            st_nxt.rdat = {3'h0, st_r.s2.los, st_r.s2.level};     // RULE_08
          ADR_RT_STATUS:   st_nxt.rdat = {5'h00, rt, 1'b0};      // RULE_16
          default:         st_nxt.rdat = 8'h00;
        endcase
      end
      // Writes commit on the edge where the master sees ack
      if (req & st_r.ack & wb_we_i & wb_sel_i[0]) begin
        case (wb_adr_i)
          ADR_LINE_CTRL_1: st_nxt.lc1 = wb_dat_i[7:0];
          ADR_TX_GAIN:     st_nxt.txg = {1'b0, wb_dat_i[6:0]};
          ADR_LINE_CTRL_2: st_nxt.lc2 = wb_dat_i[7:0];
          ADR_LINE_CTRL_3: st_nxt.lc3 = {6'h00, wb_dat_i[1:0]};
          ADR_LINE_CTRL_4: st_nxt.lc4 = {5'h00, wb_dat_i[2:0]};   // RULE_04
          ADR_MODE_CFG:    st_nxt.mcr = wb_dat_i[7:0];
          ADR_STATUS_ONE:  clr = wb_dat_i[SR_SHORT:SR_OPEN];
          ADR_IRQ_MASK:    st_nxt.imr = wb_dat_i[SR_SHORT:SR_OPEN];
          default: ;
        endcase
      end

      // Sticky flags: a new event beats a same-cycle clear
      st_nxt.rt_prev = rt;                                       // RULE_17
      st_nxt.sr = (st_r.sr & ~clr) | (rt & ~st_r.rt_prev);       // RULE_22
      st_nxt.irq = |(st_r.sr & st_r.imr);                         // RULE_22

      // Scaled master clock
      if (st_r.div_cnt == MCLK_HALF_CYC - 8'h01) begin
        st_nxt.div_cnt = 8'h00;
        st_nxt.mclk_sc = ~st_r.mclk_sc;
      end else begin
        st_nxt.div_cnt = st_r.div_cnt + 8'h01;
      end

      // Receive clock: scaled master clock during loss, else square-wave sync input or recovered clock
      if (st_r.s2.los) begin
        st_nxt.rx_clk = st_r.mclk_sc;                            // RULE_06
      end else if (rxm == MODE_SYNC) begin
        st_nxt.rx_clk = st_r.s2.rpos;                            // RULE_09
      end else begin
        st_nxt.rx_clk = st_r.s2.rclk;
      end

      case (st_r.lc2[LC2_SRC_LO+1:LC2_SRC_LO])                   // RULE_12
        SRC_RECOV: tx_sel = st_r.rx_clk;
        SRC_MCLK:  tx_sel = st_r.mclk_sc;
        SRC_TX_CLOCK_IN:  tx_sel = st_r.s2.tx_clock_in;
        SRC_PLL:   tx_sel = st_r.s2.pll_clk;
        default:   tx_sel = 1'b0;
      endcase
      tx_rise = tx_sel & ~st_r.txclk_prev;
      st_nxt.txclk_prev = tx_sel;
      st_nxt.pay_clk = tx_sel;                                   // RULE_02
      st_nxt.take = tx_rise;

      // Violation request arms once per rising edge of the bit
      st_nxt.bpv_prev = st_r.lc2[LC2_BPV];
      if (st_r.lc2[LC2_BPV] & ~st_r.bpv_prev) begin
        st_nxt.bpv = BPV_ARMED;                                  // RULE_19
      end

      // Fixed-width AMI pulses from the transmit clock edge
      if (st_r.pulse_cnt != 8'h00) begin
        st_nxt.pulse_cnt = st_r.pulse_cnt - 8'h01;
        if (st_r.pulse_cnt == 8'h01) begin
          st_nxt.tx_pos = 1'b0;                                  // RULE_13
          st_nxt.tx_neg = 1'b0;
        end
      end
      if (tx_rise) begin
        if (tx_data_i) begin
          case (st_r.bpv)
            BPV_ARMED: bpv_fire = (st_r.ones == BPV_RUN);        // RULE_19
            BPV_IDLE:  bpv_fire = 1'b0;
            default:   bpv_fire = 1'b0;
          endcase
          pol = bpv_fire ? st_r.last_pol : ~st_r.last_pol;       // RULE_23
          st_nxt.last_pol  = pol;
          st_nxt.tx_pos    = pol;
          st_nxt.tx_neg    = ~pol;
          st_nxt.pulse_cnt = TX_PULSE_CYC;                       // RULE_13
          if (st_r.ones != BPV_RUN) begin
            st_nxt.ones = st_r.ones + 2'h1;
          end
          if (bpv_fire) begin
            st_nxt.bpv = BPV_IDLE;                               // RULE_20
          end
        end else begin
          st_nxt.ones = 2'h0;
        end
      end

      st_nxt.tx_oe_n = 1'b0;
      if (txm == MODE_SYNC) begin
        st_nxt.tx_pos = tx_sel;                                  // RULE_21
        st_nxt.tx_neg = ~tx_sel;
      end
      if (txm == MODE_6312 || !st_r.lc1[LC1_PWR_N]) begin
        st_nxt.tx_pos  = 1'b0;                                   // RULE_02
        st_nxt.tx_neg  = 1'b0;
        st_nxt.tx_oe_n = 1'b1;                                   // RULE_18
        st_nxt.pulse_cnt = 8'h00;
      end

      st_nxt.cfg.rx_term_sel      = st_r.lc4[2:0];               // RULE_04
      st_nxt.cfg.rx_gain_limit    = st_r.lc1[LC1_GLIM];          // RULE_05
      st_nxt.cfg.monitor_gain_sel = st_r.lc3[1:0];               // RULE_10
      st_nxt.cfg.tx_waveform_mode = txm;                         // RULE_11
      st_nxt.cfg.line_buildout_sel = st_r.lc1[LC1_LBO_LO+2:LC1_LBO_LO];
      st_nxt.cfg.agc_en           = st_r.txg[TXG_AGC];           // RULE_14
      st_nxt.cfg.gain_code        = st_r.txg[5:0];               // RULE_14
      st_nxt.cfg.current_limit_en = ~st_r.lc2[LC2_SHORT_LIMIT_DISABLE];         // RULE_15
      st_nxt.cfg.ja_en = ~st_r.lc1[LC1_JA_DIS] &
                         (ja_mode == MODE_T1 || ja_mode == MODE_E1); // RULE_03
      st_nxt.cfg.ja_tx_side  = st_r.lc1[LC1_JA_TX];
      st_nxt.cfg.ja_depth_32 = st_r.lc1[LC1_JA_32];
      st_nxt.cfg.ja_rx_path  = st_r.cfg.ja_en & ~st_r.cfg.ja_tx_side; // RULE_07
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r         <= '0;
      st_r.bpv     <= BPV_IDLE;
      st_r.tx_oe_n <= 1'b1;
      st_r.cfg.current_limit_en <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o               = {24'h000000, st_r.rdat};
  assign wb_ack_o               = st_r.ack;
  assign tx_line_pos_o          = st_r.tx_pos;
  assign tx_line_neg_o          = st_r.tx_neg;
  assign tx_line_oe_n_o         = st_r.tx_oe_n;
  assign tx_bit_taken_o         = st_r.take;
  assign rx_clock_out_o         = st_r.rx_clk;
  assign tx_payload_clock_out_o = st_r.pay_clk;
  assign irq_o                  = st_r.irq;
  assign cfg_o                  = st_r.cfg;

  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_no_line_6312: assert property ( // RULE_02
    ce_i && txm == MODE_6312 |=> !tx_line_pos_o && !tx_line_neg_o
      && tx_line_oe_n_o)
    else $error("line driven in 6312 mode");
  chk_power_down_float: assert property ( // RULE_18
    ce_i && !st_r.lc1[LC1_PWR_N] |=> tx_line_oe_n_o && !tx_line_pos_o)
    else $error("driver active while powered down");
  chk_los_fallback: assert property ( // RULE_06
    ce_i && st_r.s2.los |=> rx_clock_out_o == $past(st_r.mclk_sc))
    else $error("receive clock not from master during loss");
  chk_limit_enable: assert property ( // RULE_15
    ce_i |=> cfg_o.current_limit_en == !$past(st_r.lc2[LC2_SHORT_LIMIT_DISABLE]))
    else $error("limiter enable wrong");
  chk_short_latch: assert property ( // RULE_16
    ce_i && st_r.s2.short_det && !st_r.rt_prev[SR_SHORT]
      |=> st_r.sr[SR_SHORT] ##1 (st_r.sr[SR_SHORT] || !ce_i || $past(req)))
    else $error("short event not latched");
  chk_open_latch: assert property ( // RULE_17
    ce_i && st_r.s2.open_det && !st_r.rt_prev[SR_OPEN]
      |=> st_r.sr[SR_OPEN])
    else $error("open event not latched");
  chk_irq_masked: assert property ( // RULE_22
    ce_i |=> irq_o == |($past(st_r.sr) & $past(st_r.imr)))
    else $error("interrupt does not follow masked flags");
  chk_ja_modes: assert property ( // RULE_03
    ce_i && !(ja_mode == MODE_T1 || ja_mode == MODE_E1) |=> !cfg_o.ja_en)
    else $error("jitter attenuator enabled in wrong mode");
  chk_level_read: assert property ( // RULE_08
    ce_i && req && !st_r.ack && wb_adr_i == ADR_INFO_ONE
      |=> wb_dat_o[3:0] == $past(st_r.s2.level))
    else $error("level code read wrong");
  chk_bpv_once: assert property ( // RULE_20
    ce_i && bpv_fire |=> st_r.bpv == BPV_IDLE)
    else $error("violation stays armed");
  chk_bpv_polarity: assert property ( // RULE_23
    ce_i && bpv_fire |=> st_r.last_pol == $past(st_r.last_pol)
      && st_r.pulse_cnt == TX_PULSE_CYC)
    else $error("violation polarity wrong");

  chk_ack_answer: assert property (
    ce_i && req && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  chk_sync_tx_line: assert property ( // RULE_21
    ce_i && txm == MODE_SYNC && st_r.lc1[LC1_PWR_N]
      |=> tx_line_pos_o == $past(tx_sel) && tx_line_neg_o != $past(tx_sel))
    else $error("sync clock not on line");
  chk_rx_sync_clock: assert property ( // RULE_09
    ce_i && !st_r.s2.los && rxm == MODE_SYNC
      |=> rx_clock_out_o == $past(st_r.s2.rpos))
    else $error("receive clock not from sync input");
  chk_rx_recovered: assert property ( // RULE_06
    ce_i && !st_r.s2.los && rxm != MODE_SYNC
      |=> rx_clock_out_o == $past(st_r.s2.rclk))
    else $error("receive clock not recovered clock");
  chk_div_range: assert property ( // RULE_06
    st_r.div_cnt < MCLK_HALF_CYC)
    else $error("master clock divider out of range");
  chk_pay_clock: assert property ( // RULE_02
    ce_i |=> tx_payload_clock_out_o == $past(tx_sel))
    else $error("payload clock not the selected clock");
  chk_src_tx_clock_in: assert property ( // RULE_12
    ce_i && st_r.lc2[LC2_SRC_LO+1:LC2_SRC_LO] == SRC_TX_CLOCK_IN
      |=> tx_payload_clock_out_o == $past(st_r.s2.tx_clock_in))
    else $error("external transmit clock not selected");
  chk_take_pulse: assert property ( // RULE_13
    ce_i |=> tx_bit_taken_o == $past(tx_rise))
    else $error("bit taken pulse wrong");
  chk_pulse_end: assert property ( // RULE_13
    ce_i && st_r.pulse_cnt == 8'h01 && !tx_rise && txm != MODE_SYNC
      |=> !tx_line_pos_o && !tx_line_neg_o)
    else $error("pulse longer than fixed width");
  chk_oe_on: assert property ( // RULE_18
    ce_i && st_r.lc1[LC1_PWR_N] && txm != MODE_6312
      |=> !tx_line_oe_n_o)
    else $error("driver floated while powered");

  chk_term_cfg: assert property ( // RULE_04
    ce_i |=> cfg_o.rx_term_sel == $past(st_r.lc4[2:0]))
    else $error("termination select wrong");
  chk_gain_limit: assert property ( // RULE_05
    ce_i |=> cfg_o.rx_gain_limit == $past(st_r.lc1[LC1_GLIM]))
    else $error("gain limit wrong");
  chk_monitor_sel: assert property ( // RULE_10
    ce_i |=> cfg_o.monitor_gain_sel == $past(st_r.lc3[1:0]))
    else $error("monitor gain select wrong");
  chk_wave_mode: assert property ( // RULE_11
    ce_i |=> cfg_o.tx_waveform_mode == $past(txm))
    else $error("transmit waveform mode wrong");
  chk_agc_mode: assert property ( // RULE_14
    ce_i |=> cfg_o.agc_en == $past(st_r.txg[TXG_AGC]))
    else $error("gain mode wrong");
  chk_ja_rx_path: assert property ( // RULE_07
    ce_i |=> cfg_o.ja_rx_path == $past(cfg_o.ja_en && !cfg_o.ja_tx_side))
    else $error("receive path attenuator flag wrong");
  chk_bpv_arm: assert property ( // RULE_19
    ce_i && st_r.lc2[LC2_BPV] && !st_r.bpv_prev && !bpv_fire
      |=> st_r.bpv == BPV_ARMED)
    else $error("violation request not armed");
  chk_sticky_hold: assert property ( // RULE_22
    ce_i && st_r.sr[SR_OPEN] && !clr[SR_OPEN]
      |=> st_r.sr[SR_OPEN])
    else $error("latched flag lost without clear");
  chk_clear_flag: assert property ( // RULE_22
    ce_i && clr[SR_SHORT] && !rt[SR_SHORT]
      |=> !st_r.sr[SR_SHORT])
    else $error("latched flag not cleared");

  cov_bpv_fire:  cover property (ce_i && bpv_fire);
  cov_irq_rise:  cover property ($rose(irq_o));
  cov_los_clock: cover property (st_r.s2.los ##1 $rose(rx_clock_out_o));
  cov_wb_write:  cover property (wb_ack_o && wb_we_i);
  cov_open_rise: cover property (ce_i && rt[SR_OPEN] && !st_r.rt_prev[SR_OPEN]);

endmodule

// [bench/lics_line_model.sv]
module lics_line_model #(
  parameter int RH = 7,
  parameter int TH = 30,
  parameter int PH = 11,
  parameter int SH = 5
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      rclk_o,
  output logic      tx_clock_in_o,
  output logic      pll_o,
  output logic      rpos_o,
  output logic      rneg_o
);
  timeunit 1ns;
  timeprecision 1ps;

  int cnt;

  // Free running line clocks, each on its own half period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt    <= 0;
      rclk_o <= 1'b0;
      tx_clock_in_o <= 1'b0;
      pll_o  <= 1'b0;
      rpos_o <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      if ((cnt + 1) % RH == 0) rclk_o <= ~rclk_o;
      if ((cnt + 1) % TH == 0) tx_clock_in_o <= ~tx_clock_in_o;
      if ((cnt + 1) % PH == 0) pll_o <= ~pll_o;
      if ((cnt + 1) % SH == 0) rpos_o <= ~rpos_o;
    end
  end

  // Square-wave sync signal drives both line legs in opposition
  assign rneg_o = ~rpos_o;
endmodule

// [bench/tb.sv]
module tb
  import lics_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int RH = 7;
  localparam int TH = 30;
  localparam int PH = 11;
  localparam int SH = 5;
  localparam logic [7:0] AD [6] = '{ADR_LINE_CTRL_1, ADR_TX_GAIN,
    ADR_LINE_CTRL_2, ADR_LINE_CTRL_3, ADR_LINE_CTRL_4, ADR_MODE_CFG};
  localparam logic [7:0] MK [6] = '{8'hFF, 8'h7F, 8'h2E, 8'h03, 8'h07, 8'hFF};

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  sel = 4'hF;
  logic        short_det = 1'b0, open_det = 1'b0, los = 1'b0;
  logic        tx_data = 1'b1;
  logic [3:0]  level = 4'h0;
  logic        rclk, tx_clock_in, pll, rpos, rneg;
  logic [31:0] rdat;
  logic        ack, tx_pos, tx_neg, oe_n, taken, rx_out, pay, irq;
  lics_cfg_s   cfg;
  logic        rx_q, pay_q, last_pol;
  logic [31:0] seed = 32'h0da1;
  int          failures = 0, compares = 0, cycles = 0;
  int          rx_tog = 0, pay_tog = 0, reps = 0, run = 0, last_run = 0;

  initial forever #5 clk_i = ~clk_i;

  lics_line_model #(.RH(RH), .TH(TH), .PH(PH), .SH(SH)) u_lics_line_model (
    .clk_i(clk_i), .rst_i(rst_i), .rclk_o(rclk), .tx_clock_in_o(tx_clock_in),
    .pll_o(pll), .rpos_o(rpos), .rneg_o(rneg));

  lics_line_ctrl u_lics_line_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rx_line_pos_i(rpos), .rx_line_neg_i(rneg), .rx_clk_rec_i(rclk),
    .tx_clock_in_i(tx_clock_in), .tx_pll_clk_i(pll), .short_det_i(short_det),
    .open_det_i(open_det), .rx_signal_lost_i(los),
    .rx_level_code_i(level), .tx_data_i(tx_data),
    .tx_line_pos_o(tx_pos), .tx_line_neg_o(tx_neg),
    .tx_line_oe_n_o(oe_n), .tx_bit_taken_o(taken),
    .rx_clock_out_o(rx_out), .tx_payload_clock_out_o(pay),
    .irq_o(irq), .cfg_o(cfg));

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Edge counters, pulse width and mark polarity history
  always @(negedge clk_i) begin
    cycles <= cycles + 1;
    rx_q <= rx_out;
    pay_q <= pay;
    if (rx_q !== rx_out) rx_tog <= rx_tog + 1;
    if (pay_q !== pay) pay_tog <= pay_tog + 1;
    if (tx_pos | tx_neg) run <= run + 1;
    else if (run != 0) begin
      last_run <= run;
      run <= 0;
    end
    if (taken && (tx_pos | tx_neg)) begin
      if (tx_pos === last_pol) reps <= reps + 1;
      last_pol <= tx_pos;
    end
    if (cycles == 40000) begin
      failures = failures + 1;
      wrap_up();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic ja_exp(input logic [7:0] l1, input logic [7:0] m);
    logic [3:0] md;
    md = l1[LC1_JA_TX] ? m[3:0] : m[7:4];
    return !l1[LC1_JA_DIS] && (md == MODE_T1 || md == MODE_E1);
  endfunction

  function automatic logic near(input int g, input int e);
    return (g - e <= 2) && (e - g <= 2);
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(negedge clk_i); while (ack !== 1'b1);
    chk("ack", 1, ack);
    @(posedge clk_i);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic marks(input int n);
    repeat (n) do @(negedge clk_i); while (taken !== 1'b1);
    @(posedge clk_i);
  endtask

  initial begin
    logic [7:0] q;
    logic [7:0] r [6];
    int         t0;
    int         hp [4];
    hp = '{RH, int'(MCLK_HALF_CYC), TH, PH};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("oe_rst", 1, oe_n);
    chk("lim_rst", 1, cfg.current_limit_en);
    chk("irq_rst", 0, irq);
    for (int i = 0; i < 8; i++) begin
      foreach (r[k]) r[k] = 8'(rnd());
      r[2][LC2_BPV] = 1'b0;
      r[5] = {4'(rnd() % 5), 4'(rnd() % 5)};
      foreach (r[k]) wb(1'b1, AD[k], r[k], q);
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk("term", r[4][2:0], cfg.rx_term_sel);
      chk("glim", r[0][LC1_GLIM], cfg.rx_gain_limit);
      chk("mon", r[3][1:0], cfg.monitor_gain_sel);
      chk("tmode", r[5][3:0], cfg.tx_waveform_mode);
      chk("lbo", r[0][7:5], cfg.line_buildout_sel);
      chk("agc", r[1][TXG_AGC], cfg.agc_en);
      chk("gain", r[1][5:0], cfg.gain_code);
      chk("lim", !r[2][LC2_SHORT_LIMIT_DISABLE], cfg.current_limit_en);
      chk("ja", ja_exp(r[0], r[5]), cfg.ja_en);
      chk("jad", r[0][LC1_JA_32], cfg.ja_depth_32);
      chk("jas", r[0][LC1_JA_TX], cfg.ja_tx_side);
      chk("jarx", ja_exp(r[0], r[5]) & !r[0][LC1_JA_TX],
          cfg.ja_rx_path);
      foreach (r[k]) begin
        wb(1'b0, AD[k], 8'h00, q);
        chk("readback", r[k] & MK[k], q & MK[k]);
      end
    end
    wb(1'b0, 8'h5C, 8'h00, q);
    chk("unmapped", 0, q);
    sel <= 4'h0;
    wb(1'b1, ADR_LINE_CTRL_3, ~r[3], q);
    sel <= 4'hF;
    wb(1'b0, ADR_LINE_CTRL_3, 8'h00, q);
    chk("sel0", r[3] & MK[3], q & MK[3]);
    level <= 4'(rnd());
    los <= 1'b1;
    wb(1'b1, ADR_MODE_CFG, 8'h11, q);
    wb(1'b1, ADR_LINE_CTRL_2, 8'h00, q);
    repeat (6) @(posedge clk_i);
    wb(1'b0, ADR_INFO_ONE, 8'h00, q);
    chk("info", {27'h0, 1'b1, level}, q & 8'h1F);
    t0 = rx_tog;
    repeat (480) @(posedge clk_i);
    chk("los_clk", 1, near(rx_tog - t0, 480 / hp[1]));
    los <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, ADR_LINE_CTRL_2, 8'(s << 2), q);
      repeat (20) @(posedge clk_i);
      t0 = pay_tog;
      repeat (660) @(posedge clk_i);
      chk("src", 1, near(pay_tog - t0, 660 / hp[s]));
    end
    wb(1'b1, ADR_MODE_CFG, 8'h41, q);
    repeat (20) @(posedge clk_i);
    t0 = rx_tog;
    repeat (600) @(posedge clk_i);
    chk("rx_sync", 1, near(rx_tog - t0, 600 / SH));
    wb(1'b1, ADR_LINE_CTRL_1, 8'h00, q);
    repeat (4) @(negedge clk_i);
    chk("pwr_dn", 1, oe_n);
    wb(1'b1, ADR_LINE_CTRL_1, 8'h01, q);
    wb(1'b1, ADR_LINE_CTRL_2, 8'h08, q);
    wb(1'b1, ADR_MODE_CFG, 8'h13, q);
    t0 = pay_tog;
    repeat (200) @(negedge clk_i);
    chk("m6312_oe", 1, oe_n);
    chk("m6312_line", 0, tx_pos | tx_neg);
    chk("m6312_clk", 1, near(pay_tog - t0, 200 / TH));
    wb(1'b1, ADR_MODE_CFG, 8'h14, q);
    repeat (100) @(negedge clk_i);
    chk("sync_tx", 1, tx_pos ^ tx_neg);
    wb(1'b1, ADR_MODE_CFG, 8'h11, q);
    marks(4);
    chk("e1_oe", 0, oe_n);
    chk("width", TX_PULSE_CYC, last_run);
    t0 = reps;
    marks(6);
    chk("ami", t0, reps);
    wb(1'b1, ADR_LINE_CTRL_2, 8'h28, q);
    marks(8);
    chk("bpv", t0 + 1, reps);
    marks(8);
    chk("bpv_once", t0 + 1, reps);
    wb(1'b1, ADR_LINE_CTRL_2, 8'h08, q);
    wb(1'b1, ADR_LINE_CTRL_2, 8'h28, q);
    marks(8);
    chk("bpv_again", t0 + 2, reps);
    wb(1'b1, ADR_IRQ_MASK, 8'h04, q);
    short_det <= 1'b1;
    repeat (8) @(posedge clk_i);
    wb(1'b0, ADR_RT_STATUS, 8'h00, q);
    chk("rt_short", 8'h04, q & 8'h06);
    chk("irq_short", 1, irq);
    short_det <= 1'b0;
    open_det <= 1'b1;
    repeat (8) @(posedge clk_i);
    wb(1'b0, ADR_STATUS_ONE, 8'h00, q);
    chk("latched", 8'h06, q & 8'h06);
    wb(1'b1, ADR_STATUS_ONE, 8'h04, q);
    repeat (3) @(negedge clk_i);
    chk("irq_masked", 0, irq);
    wb(1'b1, ADR_IRQ_MASK, 8'h02, q);
    repeat (3) @(negedge clk_i);
    chk("irq_open", 1, irq);
    open_det <= 1'b0;
    wb(1'b1, ADR_STATUS_ONE, 8'h02, q);
    repeat (3) @(negedge clk_i);
    chk("irq_clr", 0, irq);
    wrap_up();
  end
endmodule
